// ### common/pin_port_map.svh
// Functional notes
// - Each of the three pins has its own direction bit, independent of the others.
// - Slave select bit 4 set turns the pins into microprocessor control inputs.
// - Software sets the three direction bits to inputs before entering slave mode; the testbench enters it with them at 0.
// - Bit 7 input-full flag, read-only, reset 0, set while a word awaits reading.
// - Bit 6 output-full flag, read-only, reset 0, set until the word is read.
// - Bit 5 overflow flag set by a write onto an unread word; software clears.
// - Bit 4 selects slave port mode when 1, general I/O when 0; resets to 0.
// - Bits 2..0 set select, write, read pin directions; 1 is input; reset 1.
// - Read pin low with chip selected presents the data port to the bus.
// - Write pin rising after a low sample with chip selected loads the data port from the bus.
// - Chip select is active low; while high the strobes are ignored.
// - Every register write runs as a read followed by a modified write.
// - Port reads return pin levels; port writes update only the output latch.
// - A port read-modify-write stores sampled pin levels into the whole latch.
// - Input-full clears when the processor reads the data port input latch.
// - Output-full clears when the external processor reads the output latch.
// - Outside slave mode both full flags stay 0; overflow keeps its value.
// - On overflow the first unread word stays; the new write is dropped.
`ifndef PIN_PORT_MAP_SVH
`define PIN_PORT_MAP_SVH
`define PORT_REG_INDEX 10'h009
`define DIR_REG_INDEX 10'h089
`define IN_FULL_BIT 7
`define OUT_FULL_BIT 6
`define OVERRUN_BIT 5
`define SLAVE_SEL_BIT 4
`define DIR_RESET 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### common/pin_port_pkg.sv
package pin_port_pkg;
  // Sampled levels of the three control pins, all active low in slave mode.
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic read_n;
  } ctrl_pins_t;
  // Write channel progress of the register slave.
  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } wr_state_t;
endpackage

// ### core/three_pin_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_port_map.svh"
module three_pin_port
  import pin_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  input wire logic cpu_read_input,
  input wire logic cpu_write_output,
  output logic ext_read_active,
  output logic input_load,
  output logic input_full_flag,
  output logic output_full_flag,
  output logic input_overrun_flag,
  output logic slave_port_select
);

  ctrl_pins_t pins;
  ctrl_pins_t pins_q;
  wr_state_t wr_state;
  logic [2:0] dir;
  logic [2:0] control_pin_port;
  logic aw_held;
  logic w_held;
  logic [9:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane;
  logic commit;
  logic [7:0] old_value;
  logic [7:0] new_value;
  logic commit_dir;
  logic commit_port;
  logic ext_wr_done;
  logic ext_rd_done;
  logic accept;
  logic overflow;

  // Pins are taken as synchronous; the previous sample marks strobe ends.
  assign pins = ctrl_pins_t'(pin_in);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_q <= '1;
    end else begin
      pins_q <= pins;
    end
  end

  // A strobe completes when it rises after a low sample with select low.
  assign ext_wr_done = slave_port_select && !pins_q.select_n && !pins_q.write_n
                       && pins.write_n;
  assign ext_rd_done = slave_port_select && !pins_q.select_n && !pins_q.read_n
                       && pins.read_n;
  assign accept = ext_wr_done && (!input_full_flag || cpu_read_input);
  assign overflow = ext_wr_done && input_full_flag && !cpu_read_input;

  // Readback of either register, used for reads and for the modify step.
  function automatic logic [7:0] reg_value(input logic [9:0] index);
    logic [7:0] value;
    value = 8'h00;
    if (index == `PORT_REG_INDEX) begin
      value = {5'h00, pin_in};
    end else if (index == `DIR_REG_INDEX) begin
      value = {input_full_flag, output_full_flag, input_overrun_flag,
               slave_port_select, 1'b0, dir};
    end
    return value;
  endfunction

  // Writes read the register first and merge the enabled byte lane into it.
  always_comb begin
    old_value = reg_value(aw_index);
  end
  assign new_value = w_lane ? w_byte : old_value;
  assign commit = aw_held && w_held && (wr_state == WR_COLLECT);
  assign commit_dir = commit && (aw_index == `DIR_REG_INDEX);
  assign commit_port = commit && (aw_index == `PORT_REG_INDEX);

  // Write address channel: accepted once, held until the write commits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_index <= 10'h000;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_index <= awaddr[11:2];
    end else begin
      if (commit) begin
        aw_held <= 1'b0;
      end
      awready <= !aw_held && (wr_state == WR_COLLECT);
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_byte <= wdata[7:0];
      w_lane <= wstrb[0];
    end else begin
      if (commit) begin
        w_held <= 1'b0;
      end
      wready <= !w_held && (wr_state == WR_COLLECT);
    end
  end

  // Write response follows the commit; unmapped addresses get an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_COLLECT;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if (commit) begin
            wr_state <= WR_RESP;
            bvalid <= 1'b1;
            bresp <= (commit_dir || commit_port) ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_COLLECT;
            bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Read channel: one read at a time, data captured at the handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, reg_value(araddr[11:2])};
      rresp <= (araddr[11:2] == `PORT_REG_INDEX || araddr[11:2] == `DIR_REG_INDEX)
               ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else begin
      arready <= !rvalid;
    end
  end

  // Mode select and direction bits; the flag bits are not writable here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_port_select <= 1'b0;
      dir <= `DIR_RESET;
    end else if (commit_dir) begin
      slave_port_select <= new_value[`SLAVE_SEL_BIT];
      dir <= new_value[2:0];
    end
  end

  // Output latch; a port write stores the pin-based merged value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_pin_port <= 3'h0;
    end else if (commit_port) begin
      control_pin_port <= new_value[2:0];
    end
  end

  // Each pin drives only while its direction bit says output and not in slave mode.
  for (genvar i = 0; i < 3; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_oe[i] <= 1'b0;
        pin_out[i] <= 1'b0;
      end else begin
        pin_oe[i] <= !slave_port_select && !dir[i];
        pin_out[i] <= control_pin_port[i];
      end
    end
  end

  // Input-full: set by an accepted write, cleared by the processor read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_full_flag <= 1'b0;
    end else if (!slave_port_select) begin
      input_full_flag <= 1'b0;
    end else if (accept) begin
      input_full_flag <= 1'b1;
    end else if (cpu_read_input) begin
      input_full_flag <= 1'b0;
    end
  end

  // Output-full: set by a processor write, cleared by the external read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_full_flag <= 1'b0;
    end else if (!slave_port_select) begin
      output_full_flag <= 1'b0;
    end else if (cpu_write_output) begin
      output_full_flag <= 1'b1;
    end else if (ext_rd_done) begin
      output_full_flag <= 1'b0;
    end
  end

  // Overrun is sticky; a new event wins over a software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_overrun_flag <= 1'b0;
    end else if (overflow) begin
      input_overrun_flag <= 1'b1;
    end else if (commit_dir && !new_value[`OVERRUN_BIT]) begin
      input_overrun_flag <= 1'b0;
    end
  end

  // Bus drive request and input latch load; an overflowing write is dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_read_active <= 1'b0;
      input_load <= 1'b0;
    end else begin
      ext_read_active <= slave_port_select && !pins.select_n && !pins.read_n;
      input_load <= accept;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ext_write;
    slave_port_select && !pins.select_n && !pins.write_n ##1 pins.write_n;
  endsequence

  sequence s_ext_read;
    slave_port_select && !pins.select_n && !pins.read_n ##1 pins.read_n;
  endsequence

  property p_dir_drive;
    !slave_port_select |=> pin_oe == ~$past(dir);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("pin drive differs from dir");

  property p_slave_inputs;
    slave_port_select |=> pin_oe == 3'h0;
  endproperty
  a_slave_inputs: assert property (p_slave_inputs) else $error("pin driven in slave mode");

  property p_in_full_set;
    s_ext_write ##0 slave_port_select && !input_full_flag |=> input_full_flag && input_load;
  endproperty
  a_in_full_set: assert property (p_in_full_set) else $error("input full not set");

  property p_in_full_clear;
    input_full_flag && cpu_read_input && !ext_wr_done && slave_port_select
      |=> !input_full_flag;
  endproperty
  a_in_full_clear: assert property (p_in_full_clear) else $error("input full not cleared");

  property p_out_full_clear;
    s_ext_read ##0 !cpu_write_output |=> !output_full_flag;
  endproperty
  a_out_full_clear: assert property (p_out_full_clear) else $error("output full held");

  property p_overflow;
    s_ext_write ##0 slave_port_select && input_full_flag && !cpu_read_input
      |=> input_overrun_flag && !input_load;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow mishandled");

  property p_flags_idle;
    !slave_port_select |=> !input_full_flag && !output_full_flag;
  endproperty
  a_flags_idle: assert property (p_flags_idle) else $error("flags set outside mode");

  property p_unselected;
    pins_q.select_n |-> !ext_wr_done && !ext_rd_done;
  endproperty
  a_unselected: assert property (p_unselected) else $error("strobe taken unselected");

  property p_read_zero_bits;
    rvalid |-> rdata[31:8] == 24'h00_0000 && !rdata[3];
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits) else $error("reserved bits set");

  property p_port_rmw;
    commit_port && !w_lane |=> control_pin_port == $past(pin_in);
  endproperty
  a_port_rmw: assert property (p_port_rmw) else $error("latch not loaded from pins");

  // An unmapped write must be answered with an error and change nothing.
  property p_bad_write_resp;
    commit && !commit_dir && !commit_port |=> bvalid && bresp == `RESP_SLVERR;
  endproperty
  a_bad_write_resp: assert property (p_bad_write_resp) else $error("bad write okay");

  // A selected read strobe asks for the data bus one cycle later.
  property p_read_drive;
    slave_port_select && !pins.select_n && !pins.read_n |=> ext_read_active;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read drive missing");

endmodule
`default_nettype wire

// ### verif/ext_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_cpu_model
  import pin_port_pkg::*;
(
  input wire logic aclk,
  output ctrl_pins_t ctrl
);
  // Control lines rest high between cycles, as their pull-ups leave them.
  initial ctrl = 3'h7;

  // One bus cycle: select, strobe low for len edges, then release all lines.
  task automatic strobe(input logic wr, input logic sel, input int len);
    @(posedge aclk);
    ctrl.select_n <= ~sel;
    ctrl.write_n <= ~wr;
    ctrl.read_n <= wr;
    repeat (len) @(posedge aclk);
    ctrl <= 3'h7;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_port_map.svh"
module testbench
  import pin_port_pkg::*;
;
  localparam logic [11:0] port_addr = {`PORT_REG_INDEX, 2'b00};
  localparam logic [11:0] dir_addr = {`DIR_REG_INDEX, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r, wr_resp;
  logic [3:0] wstrb;
  logic [2:0] pin_in, pin_out, pin_oe;
  logic cpu_read_input, cpu_write_output, ext_read_active, input_load;
  logic input_full_flag, output_full_flag, input_overrun_flag, slave_port_select;
  ctrl_pins_t ext_pins;
  int n_fail, samples_checked, n_loads, n_reads;

  three_pin_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cpu_read_input(cpu_read_input), .cpu_write_output(cpu_write_output),
    .ext_read_active(ext_read_active), .input_load(input_load),
    .input_full_flag(input_full_flag), .output_full_flag(output_full_flag),
    .input_overrun_flag(input_overrun_flag), .slave_port_select(slave_port_select));
  ext_cpu_model cpu (.aclk(aclk), .ctrl(ext_pins));

  // A driven pin shows the device level; otherwise the far side drives it.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);

  // Clock generation.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counts load pulses and cycles of external read activity.
  always @(posedge aclk) begin
    if (input_load === 1'b1) n_loads <= n_loads + 1;
    if (ext_read_active === 1'b1) n_reads <= n_reads + 1;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    wr_resp = bresp;
    bready <= 1'b0;
    if (t == 200) check("wr_timeout", 32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] e);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    e = rresp;
    rready <= 1'b0;
    if (t == 200) check("rd_timeout", 32'h0, 32'h1);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] e;
    axi_rd(a, d, e);
    check(nm, exp, d);
    check({nm, "_resp"}, {30'h0, er}, {30'h0, e});
  endtask

  task automatic cpu_pulse(input logic rd);
    @(posedge aclk);
    cpu_read_input <= rd;
    cpu_write_output <= ~rd;
    @(posedge aclk);
    cpu_read_input <= 1'b0;
    cpu_write_output <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    $display("Error watchdog expected finish seen timeout");
    n_fail++;
    complete_run;
  end

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {cpu_read_input, cpu_write_output, awaddr, araddr, wdata} = '0;
    {n_fail, samples_checked, n_loads, n_reads} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check("oe_reset", 32'h0, pin_oe);
    rd_chk("dir_reset", dir_addr, 32'h07, `RESP_OKAY);
    axi_wr(dir_addr, 8'hCA);
    check("wr_resp", `RESP_OKAY, wr_resp);
    repeat (2) @(posedge aclk);
    rd_chk("dir_ro", dir_addr, 32'h02, `RESP_OKAY);
    check("oe_mix", 32'h5, pin_oe);
    $display("test direction done");
    axi_wr(dir_addr, 8'h00);
    axi_wr(port_addr, 8'h05);
    repeat (2) @(posedge aclk);
    check("latch", 32'h5, pin_out);
    rd_chk("port_out", port_addr, 32'h05, `RESP_OKAY);
    axi_wr(dir_addr, 8'h07);
    repeat (2) @(posedge aclk);
    axi_rd(port_addr, v, r);
    check("port_in", 32'h07, v);
    axi_wr(port_addr, v[7:0] & 8'hFE);
    axi_wr(dir_addr, 8'h00);
    repeat (2) @(posedge aclk);
    check("latch_rmw", 32'h6, pin_out);
    // A write without its byte lane stores the pin levels, the input pin included.
    axi_wr(dir_addr, 8'h01);
    wstrb <= 4'h0;
    axi_wr(port_addr, 8'h00);
    wstrb <= 4'hF;
    axi_wr(dir_addr, 8'h00);
    repeat (2) @(posedge aclk);
    check("latch_pins", 32'h7, pin_out);
    $display("test port done");
    axi_wr(dir_addr, 8'h10);
    repeat (2) @(posedge aclk);
    check("oe_slave", 32'h0, pin_oe);
    check("mode", 32'h1, slave_port_select);
    axi_wr(dir_addr, 8'h17);
    cpu.strobe(1'b1, 1'b0, 2);
    cpu.strobe(1'b1, 1'b1, 2);
    repeat (3) @(posedge aclk);
    check("loads", 32'h1, n_loads);
    rd_chk("dir_full", dir_addr, 32'h97, `RESP_OKAY);
    cpu.strobe(1'b1, 1'b1, 1);
    repeat (3) @(posedge aclk);
    check("loads_ovr", 32'h1, n_loads);
    rd_chk("dir_ovr", dir_addr, 32'hB7, `RESP_OKAY);
    cpu_pulse(1'b1);
    rd_chk("dir_taken", dir_addr, 32'h37, `RESP_OKAY);
    axi_wr(dir_addr, 8'h17);
    repeat (2) @(posedge aclk);
    check("ovr_clr", 32'h0, input_overrun_flag);
    cpu_pulse(1'b0);
    check("obf", 32'h1, output_full_flag);
    cpu.strobe(1'b0, 1'b1, 2);
    repeat (3) @(posedge aclk);
    check("ext_rd", 32'h2, n_reads);
    check("obf_clr", 32'h0, output_full_flag);
    cpu_pulse(1'b0);
    cpu.strobe(1'b1, 1'b1, 2);
    repeat (3) @(posedge aclk);
    axi_wr(dir_addr, 8'h07);
    repeat (2) @(posedge aclk);
    axi_wr(12'h100, 8'hFF);
    check("wr_resp_bad", `RESP_SLVERR, wr_resp);
    rd_chk("dir_gpio", dir_addr, 32'h07, `RESP_OKAY);
    rd_chk("unmapped", 12'h100, 32'h0, `RESP_SLVERR);
    $display("test slave done");
    complete_run;
  end
endmodule
`default_nettype wire
